//--- logic/csd_defines.svh
// Register offsets, bit positions, reset values and constants
`ifndef CSD_DEFINES_SVH
`define CSD_DEFINES_SVH

`define OFS_TEST       8'h00
`define OFS_ISG        8'h04
`define OFS_MODE       8'h08
`define OFS_TXDATA     8'h0c
`define OFS_STATUS     8'h10
`define OFS_COEF_BASE  8'h40

`define B_TX_CUT       0
`define B_RX_CUT       1
`define B_HP_BYPASS    2
`define B_RX_LOSS      3
`define B_IRQ_ARM      4
`define B_SLOT_LOOP    5
`define B_FULL_LOOP    6
`define B_TONE         7
`define B_COMPANDED    0

`define TEST_RST       8'h00
`define ISG_RST        5'h00
`define ISG_FDL_CODE   5'h10
`define COEF_RST       16'h7777

`define FRAC_W         28
`define HP_SHIFT       4
`define TONE_PEAK      16'h2000
`define TONE_MID       16'h16a1

`endif

//--- logic/csd_pkg.sv
// Shared types of the signed-digit filter channel
`default_nettype none
package csd_pkg;

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } host_req_s;

  typedef enum logic {ENG_IDLE, ENG_RUN} eng_e;

endpackage
`default_nettype wire

//--- logic/csd_channel.sv
// One codec channel: shift-add filter engine, test states, host registers
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "csd_defines.svh"

module csd_channel #(
  parameter int TAPS       = 5,
  parameter int FIR_DIGITS = 4,
  parameter int SW         = 16
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire csd_pkg::host_req_s host_req_i,
  output logic      [15:0]       rdata_o,
  input  wire logic              sample_strobe_i,
  input  wire logic [SW-1:0]     analog_in_i,
  input  wire logic [SW-1:0]     rx_slot_data_i,
  output logic      [SW-1:0]     analog_out_o,
  output logic                   analog_out_en_o,
  output logic      [SW-1:0]     pcm_transmit_out_o,
  output logic                   pcm_transmit_oe_o,
  output logic                   transmit_slot_strobe_o,
  output logic                   transmit_slot_strobe_oe_o,
  output logic                   irq_o,
  output logic                   impedance_scaling_on_o,
  output logic                   balance_path_en_o
);
  import csd_pkg::*;

  localparam int COEFS  = TAPS + 3;
  localparam int CW     = $clog2(COEFS);
  localparam int ACC_W  = SW + 4 + `FRAC_W;
  localparam logic [CW-1:0] POLE_IX = CW'(TAPS);
  localparam logic [CW-1:0] POST_IX = CW'(TAPS + 1);
  localparam logic [CW-1:0] GAIN_IX = CW'(TAPS + 2);

  typedef struct packed {
    logic [COEFS-1:0][15:0] coef;
    logic [TAPS-1:0][SW-1:0] dl;
    logic [7:0]              test;
    logic [4:0]              isg;
    logic                    companded;
    eng_e                    eng;
    logic [CW-1:0]           ci;
    logic [1:0]              di;
    logic [4:0]              csh;
    logic                    sg;
    logic signed [ACC_W-1:0] acc;
    logic [SW-1:0]           w;
    logic [SW-1:0]           rx_out;
    logic [SW-1:0]           tx_hp;
    logic [SW-1:0]           hp_avg;
    logic [SW-1:0]           slot_cap;
    logic [2:0]              tone_ix;
    logic [7:0]              tx_byte;
    logic [15:0]             rdata;
    logic [SW-1:0]           aout;
    logic                    aout_en;
    logic [SW-1:0]           pcm;
    logic                    pcm_oe;
    logic                    strobe;
    logic                    strobe_oe;
    logic                    irq;
    logic                    isc_on;
    logic                    bal_en;
  } state_s;

  state_s r_reg;
  state_s r_next;

  // Coefficient address decode: hit flag and index
  function automatic logic coef_hit(input logic [7:0] a);
    logic [7:0] d;
    d = a - `OFS_COEF_BASE;
    coef_hit = (a >= `OFS_COEF_BASE) && (d[1:0] == 2'b00)
               && (d[7:2] < 6'(COEFS));
  endfunction

  function automatic logic [CW-1:0] coef_ix(input logic [7:0] a);
    logic [7:0] d;
    d = a - `OFS_COEF_BASE;
    coef_ix = d[CW+1:2];
  endfunction

  // Index of the last term in each coefficient group
  function automatic logic [1:0] last_digit(input logic [CW-1:0] i);
    if (i < POLE_IX)
      last_digit = 2'(FIR_DIGITS - 1);
    else if (i == POST_IX)
      last_digit = 2'd1;
    else
      last_digit = 2'd3;
  endfunction

  // Digit x of a coefficient word, position 0 in the top nibble
  function automatic logic [3:0] digit_of(input logic [15:0] w,
                                          input logic [1:0]  x);
    case (x)
      2'd0:    digit_of = w[15:12];
      2'd1:    digit_of = w[11:8];
      2'd2:    digit_of = w[7:4];
      default: digit_of = w[3:0];
    endcase
  endfunction

  // Sample placed at the binary point of the accumulator
  function automatic logic signed [ACC_W-1:0] widen(input logic [SW-1:0] x);
    widen = {{(ACC_W-SW-`FRAC_W){x[SW-1]}}, x, {`FRAC_W{1'b0}}};
  endfunction

  // One period of the 1 kHz tone at eight samples per cycle
  function automatic logic [SW-1:0] tone_at(input logic [2:0] k);
    case (k)
      3'd1, 3'd3: tone_at = SW'(`TONE_MID);
      3'd2:       tone_at = SW'(`TONE_PEAK);
      3'd5, 3'd7: tone_at = SW'(16'h0000 - `TONE_MID);
      3'd6:       tone_at = SW'(16'h0000 - `TONE_PEAK);
      default:    tone_at = '0;
    endcase
  endfunction

  // Segment-compressed byte: sign, 3-bit segment, 4-bit step
  function automatic logic [7:0] compand(input logic [15:0] x);
    logic [14:0] mag;
    logic [2:0]  seg;
    logic [14:0] sh;
    mag = x[15] ? ~x[14:0] : x[14:0];
    seg = 3'd0;
    for (int i = 0; i < 7; i++)
      if (mag[i+8])
        seg = 3'(i + 1);
    // Shift sum widened so segments five to seven do not wrap
    sh = (seg == 3'd0) ? (mag >> 4) : (mag >> ({1'b0, seg} + 4'd3));
    compand = {x[15], seg, sh[3:0]};
  endfunction

  logic [3:0]              dig;
  logic [4:0]              sh_sum;
  logic                    sg_prod;
  logic [SW-1:0]           operand;
  logic signed [ACC_W-1:0] term;
  logic signed [ACC_W-1:0] acc_sum;
  logic [SW-1:0]           acc_q;
  logic [SW-1:0]           rx_in;
  logic [SW-1:0]           tx_in;
  logic [SW-1:0]           tx_word;
  logic                    full_loop;
  logic                    rx_cut;
  logic                    clr_irq;

  // Current shift-add step of the engine
  always_comb
  begin
    dig     = digit_of(r_reg.coef[r_reg.ci], r_reg.di);
    sh_sum  = r_reg.csh + {2'b00, dig[2:0]};
    sg_prod = r_reg.sg ^ dig[3];
    if (r_reg.ci < POLE_IX)
      operand = r_reg.dl[r_reg.ci];
    else if (r_reg.ci == POLE_IX)
      operand = r_reg.w;
    else if (r_reg.ci == POST_IX)
      operand = r_reg.w;
    else
      operand = r_reg.tx_hp;
    term    = widen(operand) >>> sh_sum;
    acc_sum = sg_prod ? (r_reg.acc - term)
                      : (r_reg.acc + term);
    acc_q   = acc_sum[`FRAC_W+SW-1:`FRAC_W];
  end

  // Path selection from the test states
  always_comb
  begin
    full_loop = r_reg.test[`B_FULL_LOOP]
                || (r_reg.isg == `ISG_FDL_CODE);
    rx_cut    = r_reg.test[`B_RX_CUT];
    if (rx_cut)
      rx_in = '0;
    else if (r_reg.test[`B_TONE])
      rx_in = tone_at(r_reg.tone_ix);
    else
      rx_in = rx_slot_data_i;
    // Loopback carries the previous sample's receive output
    tx_in = full_loop ? r_reg.rx_out : analog_in_i;
    tx_word = r_reg.test[`B_SLOT_LOOP] ? r_reg.slot_cap
                                       : acc_q;
  end

  // Next state: register port, sample intake and engine
  always_comb
  begin
    r_next        = r_reg;
    r_next.strobe = 1'b0;
    clr_irq       = 1'b0;

    // Register writes
    if (host_req_i.wr)
    begin
      if (host_req_i.addr == `OFS_TEST)
        r_next.test = host_req_i.wdata[7:0];
      else if (host_req_i.addr == `OFS_ISG)
        r_next.isg = host_req_i.wdata[4:0];
      else if (host_req_i.addr == `OFS_MODE)
        r_next.companded = host_req_i.wdata[`B_COMPANDED];
      else if (coef_hit(host_req_i.addr))
        r_next.coef[coef_ix(host_req_i.addr)] = host_req_i.wdata;
    end

    // Register reads, answered in the next cycle
    r_next.rdata = '0;
    if (host_req_i.rd)
    begin
      if (host_req_i.addr == `OFS_TEST)
        r_next.rdata = {8'h00, r_reg.test};
      else if (host_req_i.addr == `OFS_ISG)
        r_next.rdata = {11'h000, r_reg.isg};
      else if (host_req_i.addr == `OFS_MODE)
        r_next.rdata = {15'h0000, r_reg.companded};
      else if (host_req_i.addr == `OFS_TXDATA)
      begin
        r_next.rdata = {8'h00, r_reg.tx_byte};
        clr_irq      = 1'b1;
      end
      else if (host_req_i.addr == `OFS_STATUS)
        r_next.rdata = {13'h0000, r_reg.eng == ENG_RUN,
                        r_reg.irq, full_loop};
      else if (coef_hit(host_req_i.addr))
        r_next.rdata = r_reg.coef[coef_ix(host_req_i.addr)];
    end
    // Read clears first; an armed finishing sample further down sets and wins
    if (clr_irq)
      r_next.irq = 1'b0;

    // Static path controls
    r_next.aout_en = !full_loop;
    r_next.isc_on  = !full_loop;
    r_next.bal_en  = !rx_cut;
    if (r_reg.test[`B_TX_CUT])
    begin
      r_next.pcm_oe    = 1'b0;
      r_next.strobe_oe = 1'b0;
    end

    case (r_reg.eng)
      ENG_IDLE:
      begin
        // Strobes arriving mid-run are dropped; host must space them
        if (sample_strobe_i)
        begin
          r_next.dl[0] = rx_in;
          for (int k = 1; k < TAPS; k++)
            r_next.dl[k] = r_reg.dl[k-1];
          r_next.slot_cap = rx_slot_data_i;
          r_next.tone_ix  = r_reg.tone_ix + 3'd1;
          r_next.hp_avg   = r_reg.hp_avg
                            + SW'($signed(tx_in - r_reg.hp_avg)
                                  >>> `HP_SHIFT);
          r_next.tx_hp    = r_reg.test[`B_HP_BYPASS] ? tx_in
                            : (tx_in - r_reg.hp_avg);
          r_next.ci  = '0;
          r_next.di  = '0;
          r_next.csh = '0;
          r_next.sg  = 1'b0;
          r_next.acc = '0;
          r_next.eng = ENG_RUN;
        end
      end
      ENG_RUN:
      begin
        r_next.acc = acc_sum;
        if (r_reg.di == last_digit(r_reg.ci))
        begin
          r_next.di  = '0;
          r_next.csh = '0;
          r_next.sg  = 1'b0;
          r_next.ci  = r_reg.ci + 1'b1;
          // Pole result becomes the recursive state for post-gain
          if (r_reg.ci == POLE_IX)
          begin
            r_next.w   = acc_q;
            r_next.acc = '0;
          end
          else if (r_reg.ci == POST_IX)
          begin
            r_next.rx_out = r_reg.test[`B_RX_LOSS]
                            ? SW'($signed(acc_q) >>> 1)
                            : acc_q;
            r_next.aout   = full_loop ? '0 : r_next.rx_out;
            r_next.acc    = widen(r_reg.tx_hp);
          end
          else if (r_reg.ci == GAIN_IX)
          begin
            r_next.eng     = ENG_IDLE;
            r_next.pcm     = tx_word;
            r_next.tx_byte = r_reg.companded ? compand(16'(tx_word))
                             : tx_word[SW-1:SW-8];
            if (!r_reg.test[`B_TX_CUT])
            begin
              r_next.pcm_oe    = 1'b1;
              r_next.strobe    = 1'b1;
              r_next.strobe_oe = 1'b1;
            end
            if (r_reg.test[`B_IRQ_ARM])
              r_next.irq = 1'b1;
          end
        end
        else
        begin
          r_next.di  = r_reg.di + 2'd1;
          r_next.csh = sh_sum;
          r_next.sg  = sg_prod;
        end
      end
      default:
        r_next.eng = ENG_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      // Whole state cleared, then the documented reset words
      r_reg      <= '0;
      r_reg.test <= `TEST_RST;
      r_reg.isg  <= `ISG_RST;
      r_reg.coef <= {COEFS{`COEF_RST}};
    end
    else
      r_reg <= r_next;
  end

  // Outputs straight from the state register
  assign rdata_o                   = r_reg.rdata;
  assign analog_out_o              = r_reg.aout;
  assign analog_out_en_o           = r_reg.aout_en;
  assign pcm_transmit_out_o        = r_reg.pcm;
  assign pcm_transmit_oe_o         = r_reg.pcm_oe;
  assign transmit_slot_strobe_o    = r_reg.strobe;
  assign transmit_slot_strobe_oe_o = r_reg.strobe_oe;
  assign irq_o                     = r_reg.irq;
  assign impedance_scaling_on_o    = r_reg.isc_on;
  assign balance_path_en_o         = r_reg.bal_en;

endmodule

`default_nettype wire

//--- verification/csd_channel_sva.sv
// Port-level assertions for the signed-digit filter channel
`timescale 1ns/1ps
`default_nettype none
`include "csd_defines.svh"
module csd_channel_sva #(
  parameter int TAPS       = 5,
  parameter int FIR_DIGITS = 4
) (
  input wire logic               clk_i,
  input wire logic               rst_n_i,
  input wire csd_pkg::host_req_s host_req_i,
  input wire logic [15:0]        rdata_o,
  input wire logic               sample_strobe_i,
  input wire logic               analog_out_en_o,
  input wire logic               pcm_transmit_oe_o,
  input wire logic               transmit_slot_strobe_o,
  input wire logic               transmit_slot_strobe_oe_o,
  input wire logic               irq_o,
  input wire logic               impedance_scaling_on_o,
  input wire logic               balance_path_en_o
);
  import csd_pkg::*;
  localparam int LAT_LO = TAPS * FIR_DIGITS + 10;
  localparam int LAT_HI = LAT_LO + 2;
  logic [7:0] tst_reg;
  logic [4:0] isg_reg;
  logic       loop_on;

  // Shadow of test bits and scaling gain as the host writes them
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tst_reg <= 8'h00;
      isg_reg <= 5'h00;
    end
    else if (host_req_i.wr && host_req_i.addr == `OFS_TEST)
      tst_reg <= host_req_i.wdata[7:0];
    else if (host_req_i.wr && host_req_i.addr == `OFS_ISG)
      isg_reg <= host_req_i.wdata[4:0];
  end
  assign loop_on = tst_reg[6] || isg_reg == `ISG_FDL_CODE;

  default clocking dcb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  cut_strobe_a: assert property (
    tst_reg[0] |-> !transmit_slot_strobe_o)
    else $error("transmit strobe during cutoff");
  cut_float_a: assert property (
    $rose(sample_strobe_i) && tst_reg[0]
    |-> ##32 !pcm_transmit_oe_o && !transmit_slot_strobe_oe_o)
    else $error("transmit pins driven during cutoff");
  rx_cut_a: assert property (
    $rose(sample_strobe_i) && tst_reg[1] |-> ##32 !balance_path_en_o)
    else $error("balance path on during receive cutoff");
  loop_off_a: assert property (
    $rose(sample_strobe_i) && loop_on
    |-> ##32 !analog_out_en_o && !impedance_scaling_on_o)
    else $error("analog output on in full loopback");
  loop_clear_a: assert property (
    $rose(sample_strobe_i) && !loop_on |-> ##32 analog_out_en_o)
    else $error("analog output off outside loopback");
  sample_lat_a: assert property (
    $rose(sample_strobe_i) && !tst_reg[0]
    |-> ##[LAT_LO:LAT_HI] transmit_slot_strobe_o)
    else $error("transmit strobe late or missing");
  irq_set_a: assert property (
    transmit_slot_strobe_o && tst_reg[4] |-> irq_o)
    else $error("armed interrupt not raised");
  irq_clear_a: assert property (
    $past(host_req_i.rd) && $past(host_req_i.addr) == `OFS_TXDATA
    && !transmit_slot_strobe_o |-> !irq_o)
    else $error("interrupt not cleared by read");
  irq_quiet_a: assert property (
    !tst_reg[4] [*2] |-> !$rose(irq_o))
    else $error("interrupt raised while unarmed");
  rd_idle_a: assert property (
    !$past(host_req_i.rd) |-> rdata_o == 16'h0000)
    else $error("read data outside read slot");
endmodule

bind csd_channel csd_channel_sva #(
  .TAPS      (TAPS),
  .FIR_DIGITS(FIR_DIGITS)
) i_csd_channel_sva (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .host_req_i(host_req_i),
  .rdata_o(rdata_o), .sample_strobe_i(sample_strobe_i),
  .analog_out_en_o(analog_out_en_o), .pcm_transmit_oe_o(pcm_transmit_oe_o),
  .transmit_slot_strobe_o(transmit_slot_strobe_o),
  .transmit_slot_strobe_oe_o(transmit_slot_strobe_oe_o), .irq_o(irq_o),
  .impedance_scaling_on_o(impedance_scaling_on_o),
  .balance_path_en_o(balance_path_en_o)
);
`default_nettype wire

//--- verification/host_model.sv
// Host processor model driving the channel's command port
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic               clk_i,
  output var  csd_pkg::host_req_s req_o
);
  import csd_pkg::*;

  // Idle port from time zero
  initial req_o = '0;

  // One-cycle write strobe beside address and data
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    req_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    req_o.wr <= 1'b0;
  endtask

  // One-cycle read strobe; data comes back in the next cycle
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    req_o <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    req_o.rd <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the signed-digit filter channel
`timescale 1ns/1ps
`default_nettype none
`include "csd_defines.svh"
module testbench;
  import csd_pkg::*;
  localparam int TAPS = 5;
  logic        clk_i, rst_n_i, smp_stb, rd_seen;
  host_req_s   host_req;
  logic [15:0] rdata, analog_in, rx_slot, aout, pcm;
  logic        aout_en, pcm_oe, transmit_slot_strobe, tsc_oe, irq, isc_on, bal_en;
  logic [15:0] exp_rd_q[$];
  logic [31:0] exp_smp_q[$];
  int          error_cnt, num_checks, cyc;
  logic [15:0] last_ro, hp_m;
  logic        law_on;

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  csd_channel #(.TAPS(TAPS)) i_csd_channel (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .host_req_i(host_req),
    .rdata_o(rdata), .sample_strobe_i(smp_stb), .analog_in_i(analog_in),
    .rx_slot_data_i(rx_slot), .analog_out_o(aout),
    .analog_out_en_o(aout_en), .pcm_transmit_out_o(pcm),
    .pcm_transmit_oe_o(pcm_oe), .transmit_slot_strobe_o(transmit_slot_strobe),
    .transmit_slot_strobe_oe_o(tsc_oe), .irq_o(irq),
    .impedance_scaling_on_o(isc_on), .balance_path_en_o(bal_en));

  host_model i_host_model (.clk_i(clk_i), .req_o(host_req));

  task automatic cmp(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Expected sample byte in companded mode: sign, segment, step
  function automatic logic [7:0] law(input logic [15:0] x);
    logic [14:0] m;
    int          s;
    m = x[15] ? ~x[14:0] : x[14:0];
    s = 0;
    while (s < 7 && m >= (15'h0100 << s))
      s++;
    law = {x[15], 3'(s), 4'(m >> ((s == 0) ? 4 : s + 3))};
  endfunction

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Match results on the falling edge, clear of output launches
  always @(negedge clk_i)
  begin
    if (rd_seen === 1'b1)
      cmp("read data", exp_rd_q.pop_front(), rdata);
    if (transmit_slot_strobe === 1'b1 && exp_smp_q.size() == 0)
    begin
      error_cnt++;
      $display("Error transmit strobe expected 0 seen 1");
    end
    else if (transmit_slot_strobe === 1'b1)
    begin
      cmp("transmit word", exp_smp_q[0][31:16], pcm);
      cmp("analog out", exp_smp_q[0][15:0], aout);
      void'(exp_smp_q.pop_front());
    end
    rd_seen <= host_req.rd;
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      conclude();
    end
  end

  // One sample under given test bits, scaling gain and transmit gain
  task automatic run_smp(input int n, input logic [7:0] bits,
                         input logic [4:0] isg, input logic [15:0] gain,
                         input int pk, input int ak);
    logic [31:0]        r;
    logic [15:0]        ax, rx, pe, ae, xi, hx, ro;
    logic signed [17:0] t;
    i_host_model.wr(`OFS_TEST, {8'h00, bits});
    i_host_model.wr(`OFS_ISG, {11'h000, isg});
    i_host_model.wr(`OFS_COEF_BASE + 8'(4 * (TAPS + 2)), gain);
    r  = $urandom;
    ax = {r[14], r[14:0]};
    rx = {r[30], r[30:16]};
    // Full loopback feeds back the previous sample's receive output
    xi = (bits[6] || isg == `ISG_FDL_CODE) ? last_ro : ax;
    hx = bits[2] ? xi : xi - hp_m;
    hp_m = hp_m + 16'($signed(xi - hp_m) >>> `HP_SHIFT);
    t  = $signed(hx) * 3;
    pe = (pk == 0) ? hx : (pk == 1) ? t[16:1] :
         (pk == 2) ? {hx[15], hx[15:1]} : rx;
    ro = (ak == 3) ? `TONE_MID : bits[1] ? 16'h0000 :
         bits[3] ? {rx[15], rx[15:1]} : rx;
    ae = (ak == 2) ? 16'h0000 : ro;
    last_ro = ro;
    if (!bits[0])
      exp_smp_q.push_back({pe, ae});
    @(posedge clk_i);
    analog_in <= ax;
    rx_slot   <= rx;
    smp_stb   <= 1'b1;
    @(posedge clk_i);
    smp_stb <= 1'b0;
    repeat (40) @(posedge clk_i);
    exp_rd_q.push_back({8'h00, law_on ? law(pe) : pe[15:8]});
    i_host_model.rd(`OFS_TXDATA);
    repeat (2) @(posedge clk_i);
    $display("test %0d done", n);
  endtask

  // Main sequence
  initial
  begin
    rst_n_i   = 1'b0;
    smp_stb   = 1'b0;
    analog_in = 16'h0000;
    rx_slot   = 16'h0000;
    last_ro   = 16'h0000;
    hp_m      = 16'h0000;
    law_on    = 1'b0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    void'($urandom(32'h18db));
    exp_rd_q.push_back(`TEST_RST);
    i_host_model.rd(`OFS_TEST);
    exp_rd_q.push_back(`COEF_RST);
    i_host_model.rd(`OFS_COEF_BASE + 8'h04);
    i_host_model.wr(8'h3c, 16'h1234);
    exp_rd_q.push_back(16'h0000);
    i_host_model.rd(8'h3c);
    for (int i = 0; i < TAPS + 2; i++)
      i_host_model.wr(`OFS_COEF_BASE + 8'(4 * i), (i == 0) ? 16'h1078 :
                      (i == TAPS + 1) ? 16'h1000 : 16'h0878);
    exp_rd_q.push_back(16'h1078);
    i_host_model.rd(`OFS_COEF_BASE);
    $display("test 0 done");
    run_smp(1, 8'h04, 5'h00, 16'h0878, 0, 0);
    run_smp(2, 8'h04, 5'h00, 16'h1790, 1, 0);
    run_smp(3, 8'h04, 5'h00, 16'h9790, 2, 0);
    run_smp(4, 8'h0c, 5'h00, 16'h0878, 0, 1);
    run_smp(5, 8'h06, 5'h00, 16'h0878, 0, 2);
    run_smp(6, 8'h86, 5'h00, 16'h0878, 0, 2);
    run_smp(7, 8'h24, 5'h00, 16'h0878, 3, 0);
    run_smp(8, 8'h44, 5'h00, 16'h0878, 0, 2);
    run_smp(9, 8'h04, 5'h10, 16'h0878, 0, 2);
    run_smp(10, 8'h14, 5'h00, 16'h0878, 0, 0);
    run_smp(11, 8'h05, 5'h00, 16'h0878, 0, 0);
    run_smp(12, 8'h84, 5'h00, 16'h0878, 0, 3);
    i_host_model.wr(`OFS_MODE, 16'h0001);
    exp_rd_q.push_back(16'h0001);
    i_host_model.rd(`OFS_MODE);
    law_on = 1'b1;
    run_smp(13, 8'h04, 5'h00, 16'h0878, 0, 0);
    run_smp(14, 8'h00, 5'h00, 16'h0878, 0, 0);
    conclude();
  end
endmodule
`default_nettype wire
